// *** rtl/smc_pkg.sv ***
// Register map, field layout and switch tables for the switch matrix block
package smc_pkg;
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [31:0] RDATA_ZERO = 32'h00000000;
	// Register byte addresses
	localparam logic [31:0] GROUPED_ADDR = 32'h0000200C;
	localparam logic [31:0] INDIV_ADDR = 32'h00002150;
	localparam logic [31:0] STATUS_ADDR = 32'h000021F0;
	// Grouped register fields
	localparam int MUX_W = 4;
	localparam int EXC_MUX_LSB = 0;
	localparam int POS_MUX_LSB = 4;
	localparam int NEG_MUX_LSB = 8;
	localparam int TIA_MUX_LSB = 12;
	localparam int SRC_SEL_BIT = 16;
	localparam int TIA_SW9_BIT = 17;
	localparam int TIA_SW10_BIT = 18;
	localparam logic [3:0] MUX_RESET = 4'hF;
	localparam logic SRC_SEL_RESET = 1'b0;
	localparam logic TIA_SW_RESET = 1'b0;
	// Individual register
	localparam int EXC_W = 8;
	localparam logic [7:0] INDIV_RESET = 8'h00;
	localparam logic [7:0] INDIV_FUNC_MASK = 8'hDF;
	// Status register fields
	localparam int ST_EXC_LSB = 0;
	localparam int ST_POS_LSB = 8;
	localparam int ST_SRC_BIT = 24;
	// Switch vectors
	localparam int POS_W = 12;
	typedef logic [POS_W-1:0] smc_pos_t;
	typedef logic [EXC_W-1:0] smc_exc_t;
	typedef struct packed {
		smc_pos_t pos;
		smc_exc_t exc;
	} smc_switch_s;
	localparam smc_pos_t POS_OPEN = 12'h000;
	localparam smc_pos_t POS_LOOP = 12'h001;
	localparam smc_pos_t POS_CAL0 = 12'h002;
	localparam smc_pos_t POS_SW2 = 12'h004;
	localparam smc_pos_t POS_SW3 = 12'h008;
	localparam smc_pos_t POS_SW4 = 12'h010;
	localparam smc_pos_t POS_SW5 = 12'h020;
	localparam smc_pos_t POS_SW6 = 12'h040;
	localparam smc_pos_t POS_SW7 = 12'h080;
	localparam smc_pos_t POS_SW8 = 12'h100;
	localparam smc_pos_t POS_SW9 = 12'h200;
	localparam smc_pos_t POS_SW11 = 12'h400;
	localparam smc_pos_t POS_LOOP2 = 12'h800;
	localparam smc_exc_t EXC_OPEN = 8'h00;
	localparam smc_exc_t EXC_CAL0 = 8'h01;
	localparam smc_exc_t EXC_OUT2 = 8'h02;
	localparam smc_exc_t EXC_OUT3 = 8'h04;
	localparam smc_exc_t EXC_OUT4 = 8'h08;
	localparam smc_exc_t EXC_OUT5 = 8'h10;
	localparam smc_exc_t EXC_OUT6 = 8'h20;
	localparam smc_exc_t EXC_OUT7 = 8'h40;
	localparam smc_exc_t EXC_OUT8 = 8'h80;
	localparam smc_exc_t EXC_ALL = 8'hFF;
	// Code tables, entry 15 first
	localparam logic [16*POS_W-1:0] POS_TABLE = {
		POS_OPEN, POS_LOOP2, POS_LOOP2, POS_OPEN,
		POS_SW11, POS_OPEN, POS_SW9, POS_SW8,
		POS_SW7, POS_SW6, POS_SW5, POS_SW4,
		POS_SW3, POS_SW2, POS_CAL0, POS_LOOP};
	localparam logic [16*EXC_W-1:0] EXC_TABLE = {
		EXC_OPEN, EXC_OPEN, EXC_OPEN, EXC_OPEN,
		EXC_OPEN, EXC_OPEN, EXC_ALL, EXC_OUT8,
		EXC_OUT7, EXC_OUT6, EXC_OUT5, EXC_OUT4,
		EXC_OUT3, EXC_OUT2, EXC_CAL0, EXC_OPEN};
endpackage : smc_pkg

// *** rtl/smc_mux_decode.sv ***
// Table lookup from a grouped mux code to its switch-close pattern
`timescale 1ns/100ps
module smc_mux_decode #(
	parameter int WIDTH = 8,
	parameter logic [16*WIDTH-1:0] TABLE = '0
) (
	input wire logic [3:0] code,
	output logic [WIDTH-1:0] closed
);
	// Every code has an entry, so no illegal input exists
	assign closed = TABLE[code*WIDTH +: WIDTH];
endmodule : smc_mux_decode

// *** rtl/smc_switch_regs.sv ***
// Switch matrix control registers on AHB-Lite with switch-close outputs
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - Positive codes 0101..1001 close only positive switch 5..9
// - Positive code 1011 closes only switch 11; 1010 and 1100 reserved
// - Positive 1101, 1110 close second loop switch; 1111 opens all
// - Excitation mux field is grouped bits [3:0], read/write, reset 0xF
// - Excitation code 0000 opens all; 0001 closes cal resistor switch
// - Excitation codes 0010..1000 close output switch 2..8 alone
// - Excitation code 1001 closes all; 1010..1111 open all
// - Individual register resets to zero; each bit 1 except bit 5 closes its switch
// - Individual bits [31:8] read zero; bit 5 has no switch function
// - Individual bit 7 drives output switch 8, bit 6 switch 7
// - Individual bit 4 drives output switch 5 to counter electrode
// - Individual bits 3, 2, 1 drive output switches 4, 3, 2
// - Individual bit 0 drives the cal resistor 0 output switch
// - Grouped bit 16 selects individual (1) or grouped (0) control
module smc_switch_regs (
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	output smc_pkg::smc_switch_s SW_CLOSE
);
	import smc_pkg::*;

	// Address phase capture
	logic ap_take;
	logic ap_read;
	logic dp_valid;
	logic dp_write;
	logic dp_word;
	logic [31:0] dp_addr;
	logic next_dp_valid;
	logic next_dp_write;
	logic next_dp_word;
	logic [31:0] next_dp_addr;

	// Grouped register fields
	logic switch_source_select;
	logic tia_sw9;
	logic tia_sw10;
	logic [3:0] tia_mux_field;
	logic [3:0] neg_mux_field;
	logic [3:0] positive_group_mux_field;
	logic [3:0] excitation_output_mux_field;
	logic next_switch_source_select;
	logic next_tia_sw9;
	logic next_tia_sw10;
	logic [3:0] next_tia_mux_field;
	logic [3:0] next_neg_mux_field;
	logic [3:0] next_positive_group_mux_field;
	logic [3:0] next_excitation_output_mux_field;

	// Individual register
	logic [7:0] excitation_output_switch_individual;
	logic [7:0] next_excitation_output_switch_individual;

	// Write decode
	logic wr_commit;
	logic wr_grouped;
	logic wr_indiv;

	// Read decode
	logic rd_grouped;
	logic rd_indiv;
	logic rd_status;
	logic [31:0] next_grouped_word;
	logic [31:0] next_indiv_word;
	logic [31:0] status_word;
	logic [31:0] rd_mux;
	logic [31:0] next_rdata;

	// Switch selection
	smc_pos_t pos_grouped;
	smc_exc_t exc_grouped;
	smc_exc_t exc_indiv;
	smc_pos_t pos_selected;
	smc_exc_t exc_selected;
	smc_switch_s next_sw_close;

	// Zero wait states, so the slave never stretches a transfer
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// Address phase is taken only when the bus says the slot is free
	assign ap_take = HSEL && (HTRANS == HTRANS_NONSEQ) && HREADY;
	assign ap_read = ap_take && !HWRITE;

	assign next_dp_valid = ap_take;
	assign next_dp_write = ap_take && HWRITE;
	assign next_dp_word = ap_take && (HSIZE == HSIZE_WORD);
	assign next_dp_addr = ap_take ? HADDR : dp_addr;

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_word <= 1'b0;
			dp_addr <= 32'h00000000;
		end else begin
			dp_valid <= next_dp_valid;
			dp_write <= next_dp_write;
			dp_word <= next_dp_word;
			dp_addr <= next_dp_addr;
		end
	end

	// Sub-word writes are dropped; partial lane merge not worth the area
	assign wr_commit = dp_valid && dp_write && dp_word && HREADY;
	assign wr_grouped = wr_commit && (dp_addr == GROUPED_ADDR);
	assign wr_indiv = wr_commit && (dp_addr == INDIV_ADDR);

	// Grouped register next values
	assign next_switch_source_select = wr_grouped ?
		HWDATA[SRC_SEL_BIT] : switch_source_select;
	assign next_tia_sw9 = wr_grouped ?
		HWDATA[TIA_SW9_BIT] : tia_sw9;
	assign next_tia_sw10 = wr_grouped ?
		HWDATA[TIA_SW10_BIT] : tia_sw10;
	assign next_tia_mux_field = wr_grouped ?
		HWDATA[TIA_MUX_LSB +: MUX_W] : tia_mux_field;
	assign next_neg_mux_field = wr_grouped ?
		HWDATA[NEG_MUX_LSB +: MUX_W] : neg_mux_field;
	assign next_positive_group_mux_field = wr_grouped ?
		HWDATA[POS_MUX_LSB +: MUX_W] : positive_group_mux_field;
	assign next_excitation_output_mux_field = wr_grouped ?
		HWDATA[EXC_MUX_LSB +: MUX_W] :
		excitation_output_mux_field;

	// Individual register next value, upper bits never stored
	assign next_excitation_output_switch_individual = wr_indiv ?
		HWDATA[EXC_W-1:0] :
		excitation_output_switch_individual;

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			switch_source_select <= SRC_SEL_RESET;
			tia_sw9 <= TIA_SW_RESET;
			tia_sw10 <= TIA_SW_RESET;
			tia_mux_field <= MUX_RESET;
			neg_mux_field <= MUX_RESET;
			positive_group_mux_field <= MUX_RESET;
			excitation_output_mux_field <= MUX_RESET;
		end else begin
			switch_source_select <= next_switch_source_select;
			tia_sw9 <= next_tia_sw9;
			tia_sw10 <= next_tia_sw10;
			tia_mux_field <= next_tia_mux_field;
			neg_mux_field <= next_neg_mux_field;
			positive_group_mux_field <= next_positive_group_mux_field;
			excitation_output_mux_field <=
				next_excitation_output_mux_field;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			excitation_output_switch_individual <= INDIV_RESET;
		end else begin
			excitation_output_switch_individual <=
				next_excitation_output_switch_individual;
		end
	end

	// Readback words built from next values, so a read right after
	// a write to the same register returns the new contents
	always_comb begin
		next_grouped_word = RDATA_ZERO;
		next_grouped_word[SRC_SEL_BIT] = next_switch_source_select;
		next_grouped_word[TIA_SW9_BIT] = next_tia_sw9;
		next_grouped_word[TIA_SW10_BIT] = next_tia_sw10;
		next_grouped_word[TIA_MUX_LSB +: MUX_W] = next_tia_mux_field;
		next_grouped_word[NEG_MUX_LSB +: MUX_W] = next_neg_mux_field;
		next_grouped_word[POS_MUX_LSB +: MUX_W] =
			next_positive_group_mux_field;
		next_grouped_word[EXC_MUX_LSB +: MUX_W] =
			next_excitation_output_mux_field;
	end

	always_comb begin
		next_indiv_word = RDATA_ZERO;
		next_indiv_word[EXC_W-1:0] =
			next_excitation_output_switch_individual;
	end

	// Status shows the switch state actually driven right now
	always_comb begin
		status_word = RDATA_ZERO;
		status_word[ST_EXC_LSB +: EXC_W] = SW_CLOSE.exc;
		status_word[ST_POS_LSB +: POS_W] = SW_CLOSE.pos;
		status_word[ST_SRC_BIT] = switch_source_select;
	end

	// Unmapped reads return zero with an OKAY response
	assign rd_grouped = ap_read && (HADDR == GROUPED_ADDR);
	assign rd_indiv = ap_read && (HADDR == INDIV_ADDR);
	assign rd_status = ap_read && (HADDR == STATUS_ADDR);
	assign rd_mux = ({32{rd_grouped}} & next_grouped_word) |
		({32{rd_indiv}} & next_indiv_word) |
		({32{rd_status}} & status_word);
	assign next_rdata = ap_read ? rd_mux : RDATA_ZERO;

	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			HRDATA <= RDATA_ZERO;
		end else begin
			HRDATA <= next_rdata;
		end
	end

	// Grouped positive decode
	smc_mux_decode #(
		.WIDTH(POS_W),
		.TABLE(POS_TABLE)
	) u_pos_decode (
		.code(positive_group_mux_field),
		.closed(pos_grouped)
	);

	// Grouped excitation decode
	smc_mux_decode #(
		.WIDTH(EXC_W),
		.TABLE(EXC_TABLE)
	) u_exc_decode (
		.code(excitation_output_mux_field),
		.closed(exc_grouped)
	);

	// Bit order matches switch order; bit 5 never reaches a switch
	assign exc_indiv = excitation_output_switch_individual &
		INDIV_FUNC_MASK;

	// No individual positive register here, so that group opens
	assign pos_selected = switch_source_select ?
		POS_OPEN : pos_grouped;
	assign exc_selected = switch_source_select ?
		exc_indiv : exc_grouped;

	assign next_sw_close.pos = pos_selected;
	assign next_sw_close.exc = exc_selected;

	// Registered so switch drivers never see decode glitches
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			SW_CLOSE.pos <= POS_OPEN;
			SW_CLOSE.exc <= EXC_OPEN;
		end else begin
			SW_CLOSE <= next_sw_close;
		end
	end
endmodule : smc_switch_regs

// *** tb/smc_sva.sv ***
// Port assertions for the switch matrix register block
`timescale 1ns/100ps
module smc_sva
	import smc_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic RSTN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic [31:0] HRDATA,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire smc_pkg::smc_switch_s SW_CLOSE
);
	logic ap, wg, wi;
	logic [31:0] sg, si;
	logic [7:0] xe;
	logic [11:0] xp;
	assign ap = HSEL && HTRANS == HTRANS_NONSEQ && HREADY;
	// Shadow copies, so expectations never lean on the design's decoders
	assign xe = sg[3:0] == 4'h9 ? 8'hFF : (sg[3:0] == 4'h0 ||
		sg[3:0] > 4'h9) ? 8'h00 : 8'h01 << (sg[3:0] - 4'h1);
	assign xp = sg[7:4] < 4'hA ? 12'h001 << sg[7:4] : sg[7:4] == 4'hB ?
		12'h400 : (sg[7:4] == 4'hD || sg[7:4] == 4'hE) ? 12'h800 : 12'h000;
	always_ff @(posedge CLK_SYS) begin
		if (!RSTN) begin
			wg <= 1'b0;
			wi <= 1'b0;
			sg <= 32'h0000FFFF;
			si <= 32'h00000000;
		end else begin
			wg <= ap && HWRITE && HSIZE == HSIZE_WORD && HADDR == GROUPED_ADDR;
			wi <= ap && HWRITE && HSIZE == HSIZE_WORD && HADDR == INDIV_ADDR;
			if (wg) sg <= HWDATA;
			if (wi) si <= HWDATA;
		end
	end
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);
	exc_group_a: assert property (
		!$past(sg[16]) |-> SW_CLOSE.exc == $past(xe))
		else $error("grouped excitation switches wrong");
	exc_indiv_a: assert property (
		$past(sg[16]) |-> SW_CLOSE.exc == ($past(si[7:0]) & 8'hDF))
		else $error("individual excitation switches wrong");
	pos_group_a: assert property (
		!$past(sg[16]) |-> SW_CLOSE.pos == $past(xp))
		else $error("positive switches wrong");
	pos_single_a: assert property ($onehot0(SW_CLOSE.pos))
		else $error("several positive switches closed");
	src_open_a: assert property (
		$past(sg[16]) |-> SW_CLOSE.pos == 12'h000)
		else $error("positive switches closed in individual mode");
	rst_open_a: assert property ($rose(RSTN) |-> SW_CLOSE == '0)
		else $error("switches not open after reset");
	indiv_high_a: assert property (
		ap && !HWRITE && HADDR == INDIV_ADDR |=> HRDATA[31:8] == 24'h0)
		else $error("individual upper bits not zero");
	exc_field_a: assert property (
		ap && !HWRITE && HADDR == GROUPED_ADDR |=> HRDATA[3:0] == sg[3:0])
		else $error("excitation field read back wrong");
endmodule : smc_sva
bind smc_switch_regs smc_sva chk_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
	.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
	.HREADYOUT(HREADYOUT), .HRESP(HRESP), .SW_CLOSE(SW_CLOSE));

// *** tb/smc_switch_regs_tb.sv ***
// Self-checking bench for the switch matrix control registers
`timescale 1ns/100ps
module smc_switch_regs_tb;
	import smc_pkg::*;
	logic CLK_SYS = 1'b0;
	logic RSTN = 1'b0;
	logic HSEL = 1'b0;
	logic HWRITE = 1'b0;
	logic [31:0] HADDR = '0;
	logic [31:0] HWDATA = '0;
	logic [1:0] HTRANS = 2'h0;
	logic [2:0] HSIZE = HSIZE_WORD;
	logic [31:0] HRDATA, rd;
	logic HREADYOUT, HRESP;
	smc_switch_s SW_CLOSE;
	int failures = 0;
	int n_compared = 0;
	int cyc = 0;
	smc_switch_regs dut_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .SW_CLOSE(SW_CLOSE));
	initial begin
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end
	task automatic test_done;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Entered just after a rising edge; returns just after the data edge
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] d, input logic [2:0] sz);
		HSEL <= 1'b1;
		HTRANS <= HTRANS_NONSEQ;
		HADDR <= a;
		HWRITE <= w;
		HSIZE <= sz;
		do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		// Read data taken at the same edge that sees ready high
		do begin
			@(posedge CLK_SYS);
			rd = HRDATA;
		end while (HREADYOUT !== 1'b1);
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d, HSIZE_WORD);
	endtask : wr
	task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h00000000, HSIZE_WORD);
		chk(rd, exp);
	endtask : rchk
	// Switches move one edge after the store, so look one cycle later
	task automatic swchk(input logic [11:0] p, input logic [7:0] e);
		@(posedge CLK_SYS);
		@(negedge CLK_SYS);
		chk({12'h000, SW_CLOSE}, {12'h000, p, e});
		@(posedge CLK_SYS);
	endtask : swchk
	function automatic logic [7:0] ee(input logic [3:0] c);
		if (c == 4'h9) return 8'hFF;
		if (c == 4'h0 || c > 4'h9) return 8'h00;
		return 8'h01 << (c - 4'h1);
	endfunction : ee
	function automatic logic [11:0] ep(input logic [3:0] c);
		if (c < 4'hA) return 12'h001 << c;
		if (c == 4'hB) return 12'h400;
		if (c == 4'hD || c == 4'hE) return 12'h800;
		return 12'h000;
	endfunction : ep
	task automatic t_reset;
		@(negedge CLK_SYS);
		chk({12'h000, SW_CLOSE}, 32'h00000000);
		@(posedge CLK_SYS);
		rchk(GROUPED_ADDR, 32'h0000FFFF);
		rchk(INDIV_ADDR, 32'h00000000);
	endtask : t_reset
	task automatic t_group;
		for (int c = 0; c < 16; c++) begin
			wr(GROUPED_ADDR, 32'(c * 17));
			swchk(ep(4'(c)), ee(4'(c)));
			rchk(GROUPED_ADDR, 32'(c * 17));
		end
	endtask : t_group
	task automatic t_indiv;
		wr(GROUPED_ADDR, 32'h00010011);
		swchk(12'h000, 8'h00);
		for (int k = 0; k < 8; k++) begin
			wr(INDIV_ADDR, 32'hFFFFFF00 | (32'h1 << k));
			swchk(12'h000, 8'(1 << k) & 8'hDF);
			rchk(INDIV_ADDR, 32'h1 << k);
		end
		rchk(STATUS_ADDR, 32'h01000080);
		wr(GROUPED_ADDR, 32'h00000011);
		swchk(12'h002, 8'h01);
		rchk(STATUS_ADDR, 32'h00000201);
	endtask : t_indiv
	task automatic t_refuse;
		bus(INDIV_ADDR, 1'b1, 32'h00000011, 3'h0);
		rchk(INDIV_ADDR, 32'h00000080);
		wr(32'h00002FF0, 32'hFFFFFFFF);
		rchk(32'h00002FF0, 32'h00000000);
		chk({30'h0, HREADYOUT, HRESP}, 32'h00000002);
	endtask : t_refuse
	// Reset in mid-run must drop every closed switch and both registers
	task automatic t_rerun;
		wr(GROUPED_ADDR, 32'h00000099);
		wr(INDIV_ADDR, 32'h000000FF);
		swchk(12'h200, 8'hFF);
		RSTN <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		RSTN <= 1'b1;
		@(posedge CLK_SYS);
		t_reset();
	endtask : t_rerun
	initial begin
		repeat (2) @(posedge CLK_SYS);
		RSTN <= 1'b1;
		@(posedge CLK_SYS);
		t_reset();
		t_group();
		t_indiv();
		t_refuse();
		t_rerun();
		test_done();
	end
endmodule : smc_switch_regs_tb
